// ---- src/array_processor_node_interface.sv ----
`timescale 1ns/100ps
`include "node_defines.svh"
// Contract
// - Node identity read from wired number input
// - Nodes above spare renumbered down by one
// - Correction bit subtracts one from number
// - Two cabinet bits bypass the subtraction
// - Four-bit command captured on its strobe
// - Four status bits may change each cycle
// - Network data paths carry a strobe
// - 11-bit frames, 20 ns, first on 120 ns
// - Network clock is every third system tick
// - Execution logic runs on the system clock
// - Ready and go give array lockstep
// - Coordinator commands are diagnostics only
// - Memory holds 32768 words, 48+7 bits
// - Memory addressed by memory address register
// - SECDED corrects single, flags double errors
// - Microprogram words carry parity, checked on read
// - Errors and bounds raise interrupt flags
// - One common network clock for all nodes
module array_processor_node_interface #(
    parameter int MemWords = `MEM_WORDS,
    parameter int UcodeWords = `UCODE_WORDS
) (
    input wire logic ref_clk,
    input wire logic resetn,
    // Classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Backplane identity
    input wire logic [9:0] wiredNumber,
    input wire logic spareCorrect,
    output logic [9:0] logicalNumber,
    // Array coordinator
    input wire logic [3:0] cmdCode,
    input wire logic cmdStrobe,
    input wire logic goPulse,
    output logic [3:0] statusBits,
    // Switching network
    output logic [10:0] netTxData,
    output logic netTxStrobe,
    input wire logic [10:0] netRxData,
    input wire logic netRxStrobe,
    input wire logic netRxAck,
    output logic irq
);
    // ****************************************
    // Constants and state
    // ****************************************
    localparam int SysW = $clog2(`SYS_CYC);
    localparam int FrW = $clog2(`FRAME_CYC);
    localparam int MarW = $clog2(MemWords);
    localparam int UaW = $clog2(UcodeWords);

    typedef struct packed {
        logic ack; // Bus acknowledge
        logic [31:0] rdat; // Registered read data
        logic [7:0] ists; // Sticky interrupt flags
        logic [7:0] imask; // Interrupt enables
        logic ready; // Arrived at sync point
        logic [3:0] lastCmd; // Last coordinator command
        logic cmdPrev; // Strobe edge detect
        logic goPrev; // Go edge detect
        logic [MarW-1:0] memory_address_register; // Memory address register
        logic [MarW-1:0] limit; // Highest legal address
        logic [47:0] data; // Memory data holding
        logic [7:0] inject; // Check and parity flip mask
        logic [UaW-1:0] uaddr; // Microprogram address
        logic [31:0] udata; // Microprogram data
        logic [SysW-1:0] sysCnt; // 40 ns divider
        logic [1:0] netCnt; // Network clock divider
        node_pkg::txState_t tx; // Transmit state
        logic [54:0] txWord; // Frames still to send
        logic [FrW-1:0] txPhase; // Cycle within frame
        logic [2:0] txFrame; // Frame index
        logic [10:0] txData; // Frame on the wire
        logic txStrobe; // Frame valid
        logic [FrW-1:0] rxPhase; // Cycle within frame
        logic [2:0] rxFrame; // Frames gathered
        logic [54:0] rxWord; // Assembled word
        logic [47:0] rxData; // Corrected received data
        logic [3:0] status; // Coordinator status
    } state_t;

    state_t s; // Current state
    state_t n; // Next state
    logic [54:0] mem [MemWords]; // Local memory, check bits on top
    logic [32:0] ucode [UcodeWords]; // Microprogram, parity on top
    logic memWe; // Local memory write strobe
    logic [54:0] memWd; // Local memory write word
    logic ucWe; // Microprogram write strobe
    logic [32:0] ucWd; // Microprogram write word
    logic sysTick; // One pulse per 40 ns
    logic netTick; // One pulse per 120 ns

    // ****************************************
    // Helper functions
    // ****************************************
    // Codeword position of data bit idx, skipping powers of two
    function automatic logic [5:0] dataPos(input int idx);
        int cnt;
        logic [5:0] p;
        cnt = 0;
        p = 6'h00;
        for (int q = 1; q < 55; q++) begin
            if ((q & (q - 1)) != 0) begin
                if (cnt == idx) begin
                    p = 6'(q);
                end
                cnt++;
            end
        end
        return p;
    endfunction

    // Xor of positions of set data bits
    function automatic logic [5:0] hamSum(input logic [47:0] d);
        logic [5:0] h;
        h = 6'h00;
        for (int i = 0; i < 48; i++) begin
            if (d[i]) begin
                h = h ^ dataPos(i);
            end
        end
        return h;
    endfunction

    // Word layout: overall parity, six check bits, data
    function automatic logic [54:0] eccEncode(input logic [47:0] d);
        logic [5:0] c;
        c = hamSum(d);
        return {^{c, d}, c, d};
    endfunction

    // Returns double flag, single flag, corrected data
    function automatic logic [49:0] eccCheck(input logic [54:0] w);
        logic [5:0] syn;
        logic [47:0] d;
        logic odd;
        syn = hamSum(w[47:0]) ^ w[53:48];
        odd = ^w;
        d = w[47:0];
        for (int i = 0; i < 48; i++) begin
            if (odd && dataPos(i) == syn) begin
                d[i] = ~d[i];
            end
        end
        return {!odd && syn != 6'h00, odd, d};
    endfunction

    // Byte-lane merge for partial writes
    function automatic logic [31:0] laneMerge(input logic [31:0] o, input logic [31:0] v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // Identity
    // ****************************************
    // Static levels, so no register needed
    assign logicalNumber = {wiredNumber[9:8],
                            wiredNumber[7:0] - {7'h00, spareCorrect}};

    // ****************************************
    // Clock enables
    // ****************************************
    assign sysTick = s.sysCnt == SysW'(`SYS_CYC - 1);
    assign netTick = sysTick && s.netCnt == 2'(`NET_DIV - 1);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic req;
        logic [31:0] rd;
        logic [31:0] wd;
        logic [7:0] evt;
        logic [7:0] w1c;
        logic [49:0] chk;
        logic [54:0] rw;
        logic [32:0] uw;
        req = cyc_i && stb_i;
        rd = 32'h0;
        wd = 32'h0;
        evt = 8'h00;
        w1c = 8'h00;
        chk = eccCheck(mem[s.memory_address_register]);
        rw = {netRxData, s.rxWord[54:11]};
        uw = ucode[s.uaddr];
        n = s;
        memWe = 1'b0;
        memWd = eccEncode(s.data) ^ {s.inject[6:0], 48'h0};
        ucWe = 1'b0;
        ucWd = {^s.udata ^ s.inject[7], s.udata};
        // Dividers for the slower rates
        n.sysCnt = sysTick ? '0 : s.sysCnt + 1'b1;
        if (sysTick) begin
            n.netCnt = netTick ? 2'h0 : s.netCnt + 2'h1;
        end
        // Read mux; unmapped reads give zero
        case (adr_i)
            `REG_NUMBER: rd = {6'h0, wiredNumber, 6'h0, logicalNumber};
            `REG_CONTROL: rd = {31'h0, s.ready};
            `REG_INT_STATUS: rd = {24'h0, s.ists};
            `REG_INT_MASK: rd = {24'h0, s.imask};
            `REG_ADDRESS: rd = 32'(s.memory_address_register);
            `REG_DATA_LO: rd = s.data[31:0];
            `REG_DATA_HI: rd = {16'h0, s.data[47:32]};
            `REG_LIMIT: rd = 32'(s.limit);
            `REG_INJECT: rd = {24'h0, s.inject};
            `REG_UC_ADDR: rd = 32'(s.uaddr);
            `REG_UC_DATA: rd = s.udata;
            `REG_COORD: rd = {24'h0, s.lastCmd, s.status};
            `REG_NET_CTRL: rd = {30'h0, netRxAck, s.tx != node_pkg::TX_IDLE};
            `REG_RX_LO: rd = s.rxData[31:0];
            `REG_RX_HI: rd = {16'h0, s.rxData[47:32]};
            default: rd = 32'h0;
        endcase
        wd = laneMerge(rd, dat_i, sel_i);
        // Answer one cycle after the request; ack drops after one cycle
        n.ack = req && !s.ack;
        if (req && !s.ack) begin
            n.rdat = rd;
        end
        // Writes take effect on the acknowledged edge
        if (req && s.ack && we_i) begin
            case (adr_i)
                `REG_CONTROL: begin
                    if (wd[0]) begin
                        n.ready = 1'b1;
                    end
                end
                `REG_INT_STATUS: w1c = dat_i[7:0] & {8{sel_i[0]}};
                `REG_INT_MASK: n.imask = wd[7:0];
                `REG_ADDRESS: n.memory_address_register = wd[MarW-1:0];
                `REG_DATA_LO: n.data[31:0] = wd;
                `REG_DATA_HI: n.data[47:32] = wd[15:0];
                `REG_LIMIT: n.limit = wd[MarW-1:0];
                `REG_INJECT: n.inject = wd[7:0];
                `REG_UC_ADDR: n.uaddr = wd[UaW-1:0];
                `REG_UC_DATA: begin
                    n.udata = wd;
                    ucWe = 1'b1;
                    ucWd = {^wd ^ s.inject[7], wd};
                end
                `REG_MEM_CMD: begin
                    // Out-of-range access is refused and flagged
                    if ((wd[0] || wd[1]) && s.memory_address_register > s.limit) begin
                        evt[`INT_BOUNDS] = 1'b1;
                    end else if (wd[1]) begin
                        memWe = 1'b1;
                    end else if (wd[0]) begin
                        n.data = chk[47:0];
                        evt[`INT_ECC_SGL] = chk[48];
                        evt[`INT_ECC_DBL] = chk[49];
                    end
                    if (wd[2]) begin
                        n.udata = uw[31:0];
                        evt[`INT_PARITY] = ^uw;
                    end
                end
                `REG_NET_CTRL: begin
                    if (wd[0] && s.tx == node_pkg::TX_IDLE) begin
                        n.txWord = eccEncode(s.data) ^ {s.inject[6:0], 48'h0};
                        n.tx = node_pkg::TX_WAIT;
                    end
                end
                default: ;
            endcase
        end
        // Coordinator command, sampled on the 40 ns tick
        if (sysTick) begin
            n.cmdPrev = cmdStrobe;
            n.goPrev = goPulse;
            if (cmdStrobe && !s.cmdPrev) begin
                n.lastCmd = cmdCode;
                evt[`INT_CMD] = 1'b1;
                // Diagnostic actions only
                case (cmdCode)
                    `CMD_SET_READY: n.ready = 1'b1;
                    `CMD_CLR_READY: n.ready = 1'b0;
                    `CMD_ABORT_TX: begin
                        n.tx = node_pkg::TX_IDLE;
                        n.txStrobe = 1'b0;
                    end
                    default: ;
                endcase
            end
            // Go releases a node waiting at the sync point
            if (goPulse && !s.goPrev && s.ready) begin
                n.ready = 1'b0;
                evt[`INT_GO] = 1'b1;
            end
        end
        // Network transmit
        unique case (s.tx)
            node_pkg::TX_IDLE: ;
            node_pkg::TX_WAIT: begin
                // First frame lines up with the network clock; an abort on this tick wins
                if (netTick && n.tx == node_pkg::TX_WAIT) begin
                    n.tx = node_pkg::TX_SEND;
                    n.txData = s.txWord[10:0];
                    n.txStrobe = 1'b1;
                    n.txPhase = '0;
                    n.txFrame = 3'h0;
                end
            end
            node_pkg::TX_SEND: begin
                n.txPhase = s.txPhase + 1'b1;
                if (s.txPhase == FrW'(`FRAME_CYC - 1)) begin
                    if (s.txFrame == 3'(`FRAMES_PER_WORD - 1)) begin
                        n.tx = node_pkg::TX_IDLE;
                        n.txStrobe = 1'b0;
                        evt[`INT_TX_DONE] = 1'b1;
                    end else begin
                        n.txFrame = s.txFrame + 3'h1;
                        n.txWord = {11'h0, s.txWord[54:11]};
                        n.txData = s.txWord[21:11];
                    end
                end
            end
        endcase
        // Network receive: one frame per strobed frame period
        if (netRxStrobe) begin
            n.rxPhase = s.rxPhase + 1'b1;
            if (s.rxPhase == '0) begin
                n.rxWord = rw;
                n.rxFrame = s.rxFrame + 3'h1;
                if (s.rxFrame == 3'(`FRAMES_PER_WORD - 1)) begin
                    chk = eccCheck(rw);
                    n.rxData = chk[47:0];
                    n.rxFrame = 3'h0;
                    evt[`INT_RX_DONE] = 1'b1;
                    evt[`INT_ECC_SGL] = evt[`INT_ECC_SGL] | chk[48];
                    evt[`INT_ECC_DBL] = evt[`INT_ECC_DBL] | chk[49];
                end
            end
        end else begin
            n.rxPhase = '0;
            n.rxFrame = 3'h0;
        end
        // New events win over a clear in the same cycle
        n.ists = (s.ists & ~w1c) | evt;
        // Status may change on any cycle
        n.status = {s.ists[`INT_ECC_DBL], |(s.ists & s.imask),
                    s.tx != node_pkg::TX_IDLE, s.ready};
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.limit <= MarW'(`LIMIT_RESET);
            s.tx <= node_pkg::TX_IDLE;
        end else begin
            s <= n;
        end
    end

    // ****************************************
    // Memories, no reset: contents are software's
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (memWe) begin
            mem[s.memory_address_register] <= memWd;
        end
        if (ucWe) begin
            ucode[s.uaddr] <= ucWd;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign dat_o = s.rdat;
    assign ack_o = s.ack;
    assign statusBits = s.status;
    assign netTxData = s.txData;
    assign netTxStrobe = s.txStrobe;
    assign irq = |(s.ists & s.imask);
endmodule

// ---- src/node_defines.svh ----
`ifndef NODE_DEFINES_SVH
`define NODE_DEFINES_SVH
// Timing, in nanoseconds as printed, then the network divider and the derived cycle counts
`define CLK_NS 5
`define SYS_NS 40
`define FRAME_NS 20
`define NET_DIV 3
`define SYS_CYC (`SYS_NS / `CLK_NS)
`define FRAME_CYC (`FRAME_NS / `CLK_NS)
// Geometry
`define MEM_WORDS 32768
`define UCODE_WORDS 64
`define FRAMES_PER_WORD 5
// Register byte offsets
`define REG_NUMBER 8'h00
`define REG_CONTROL 8'h04
`define REG_INT_STATUS 8'h08
`define REG_INT_MASK 8'h0c
`define REG_ADDRESS 8'h10
`define REG_DATA_LO 8'h14
`define REG_DATA_HI 8'h18
`define REG_MEM_CMD 8'h1c
`define REG_LIMIT 8'h20
`define REG_INJECT 8'h24
`define REG_UC_ADDR 8'h28
`define REG_UC_DATA 8'h2c
`define REG_COORD 8'h30
`define REG_NET_CTRL 8'h34
`define REG_RX_LO 8'h38
`define REG_RX_HI 8'h3c
// Interrupt bit positions
`define INT_CMD 0
`define INT_GO 1
`define INT_ECC_SGL 2
`define INT_ECC_DBL 3
`define INT_PARITY 4
`define INT_BOUNDS 5
`define INT_TX_DONE 6
`define INT_RX_DONE 7
// Reset values
`define LIMIT_RESET 15'h7fff
// Coordinator diagnostic command codes
`define CMD_SET_READY 4'h1
`define CMD_CLR_READY 4'h2
`define CMD_ABORT_TX 4'h3
`endif

// ---- src/node_pkg.sv ----
package node_pkg;
    // Network transmit sequencer states
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} txState_t;
endpackage

// ---- testbench/array_processor_node_interface_tb_top.sv ----
`timescale 1ns/100ps
`include "node_defines.svh"
`define CHECK(act, exp) begin check_count++; if ((act) !== (exp)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, act, exp); end end
module array_processor_node_interface_tb_top;
    logic ref_clk, resetn, cyc_i, stb_i, we_i, spareCorrect, ack_o, irq;
    logic [7:0] adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [9:0] wiredNumber, logicalNumber;
    logic [3:0] cmdCode, statusBits;
    logic cmdStrobe, goPulse, netTxStrobe, netRxStrobe, netRxAck;
    logic [10:0] netTxData, netRxData;
    logic [54:0] word; // Word last sent by the node
    int errors, check_count, n;
    logic [9:0] idW [4] = '{10'h000, 10'h2ff, 10'h180, 10'h37f};
    logic [9:0] idE [4] = '{10'h0ff, 10'h2fe, 10'h180, 10'h37e};
    logic [3:0] cmds [4] = '{4'h1, 4'h2, 4'h5, 4'h1};
    array_processor_node_interface #(.UcodeWords(16)) DUT (
        .ref_clk(ref_clk), .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .sel_i(4'hf), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .wiredNumber(wiredNumber), .spareCorrect(spareCorrect),
        .logicalNumber(logicalNumber), .cmdCode(cmdCode), .cmdStrobe(cmdStrobe),
        .goPulse(goPulse), .statusBits(statusBits), .netTxData(netTxData),
        .netTxStrobe(netTxStrobe), .netRxData(netRxData), .netRxStrobe(netRxStrobe),
        .netRxAck(netRxAck), .irq(irq));
    node_far_side farSide (.ref_clk(ref_clk), .cmdCode(cmdCode), .cmdStrobe(cmdStrobe),
        .goPulse(goPulse), .netTxData(netTxData), .netTxStrobe(netTxStrobe),
        .netRxData(netRxData), .netRxStrobe(netRxStrobe), .netRxAck(netRxAck));
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Verdict and end of run
    task automatic complete_run;
        $display("errors=%0d check_count=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One classic cycle; ack and data taken at the same edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'h0;
        @(posedge ref_clk); // Idle cycle, lets write effects land
        if (k >= 20) begin
            errors++;
            complete_run();
        end
    endtask
    // Read and compare a whole register
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        `CHECK(rd, e)
    endtask
    // Hang guard
    initial begin
        repeat (50000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
    // ****
    // Main sequence
    // ****
    initial begin
        {cyc_i, stb_i, we_i, adr_i, dat_i, spareCorrect} = '0;
        wiredNumber = 10'h0e5;
        errors = 0;
        check_count = 0;
        resetn = 1'b0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        `CHECK({irq, statusBits}, 5'h00)
        rd_chk(`REG_LIMIT, 32'h0000_7fff);
        rd_chk(8'h40, 32'h0000_0000);
        // Spare correction, cabinet bits untouched at wrap
        for (int i = 0; i < 4; i++) begin
            wiredNumber <= idW[i];
            spareCorrect <= (i != 2);
            @(posedge ref_clk);
            `CHECK(logicalNumber, idE[i])
            rd_chk(`REG_NUMBER, {6'h00, idW[i], 6'h00, idE[i]});
        end
        wb(`REG_INT_MASK, 1'b1, 32'h0000_00ff);
        // Diagnostic commands, recorded and acted on
        for (int i = 0; i < 4; i++) begin
            farSide.issue(cmds[i], 1'b0);
            wb(`REG_COORD, 1'b0, 32'h0);
            `CHECK(rd[7:4], cmds[i])
            `CHECK(statusBits[0], (i != 1 && i != 2))
            `CHECK(irq, 1'b1)
            `CHECK(statusBits[2], 1'b1)
            wb(`REG_INT_MASK, 1'b1, 32'h0);
            `CHECK(irq, 1'b0)
            wb(`REG_INT_MASK, 1'b1, 32'h0000_00ff);
            wb(`REG_INT_STATUS, 1'b1, 32'h0000_00ff);
            `CHECK(irq, 1'b0)
        end
        // Go counts only once ready
        for (int j = 0; j < 2; j++) begin
            farSide.issue(j ? `CMD_SET_READY : `CMD_CLR_READY, 1'b0);
            wb(`REG_INT_STATUS, 1'b1, 32'h0000_00ff);
            farSide.issue(4'h0, 1'b1);
            wb(`REG_INT_STATUS, 1'b0, 32'h0);
            `CHECK(rd[`INT_GO], j[0])
        end
        // Memory round trip, then one and two bad check bits
        wb(`REG_ADDRESS, 1'b1, 32'h0000_0005);
        for (int j = 0; j < 3; j++) begin
            wb(`REG_DATA_LO, 1'b1, 32'h89ab_cdef);
            wb(`REG_DATA_HI, 1'b1, 32'h0000_4567);
            wb(`REG_INJECT, 1'b1, (1 << j) - 1);
            wb(`REG_MEM_CMD, 1'b1, 32'h0000_0002);
            wb(`REG_INJECT, 1'b1, 32'h0);
            wb(`REG_INT_STATUS, 1'b1, 32'h0000_00ff);
            wb(`REG_DATA_LO, 1'b1, 32'h0);
            wb(`REG_MEM_CMD, 1'b1, 32'h0000_0001);
            if (j < 2) rd_chk(`REG_DATA_LO, 32'h89ab_cdef);
            if (j < 2) rd_chk(`REG_DATA_HI, 32'h0000_4567);
            wb(`REG_INT_STATUS, 1'b0, 32'h0);
            `CHECK(rd[3:2], (j == 0) ? 2'h0 : (j == 1) ? 2'h1 : 2'h2)
        end
        `CHECK(statusBits[3], 1'b1)
        wb(`REG_LIMIT, 1'b1, 32'h0000_0004);
        wb(`REG_MEM_CMD, 1'b1, 32'h0000_0001);
        wb(`REG_INT_STATUS, 1'b0, 32'h0);
        `CHECK(rd[`INT_BOUNDS], 1'b1)
        wb(`REG_LIMIT, 1'b1, 32'h0000_7fff);
        // Microprogram word stored with bad parity
        wb(`REG_INJECT, 1'b1, 32'h0000_0080);
        wb(`REG_UC_ADDR, 1'b1, 32'h0000_0002);
        wb(`REG_UC_DATA, 1'b1, 32'h0000_1234);
        wb(`REG_INJECT, 1'b1, 32'h0);
        wb(`REG_MEM_CMD, 1'b1, 32'h0000_0004);
        wb(`REG_INT_STATUS, 1'b0, 32'h0);
        `CHECK(rd[`INT_PARITY], 1'b1)
        // Network send of a known word
        wb(`REG_DATA_LO, 1'b1, 32'h89ab_cdef);
        wb(`REG_DATA_HI, 1'b1, 32'h0000_4567);
        wb(`REG_NET_CTRL, 1'b1, 32'h0000_0001);
        n = 0;
        while (netTxStrobe !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        while (netTxStrobe !== 1'b0 && n < 120) begin
            @(posedge ref_clk);
            n++;
        end
        `CHECK(n < 60, 1'b1)
        word = {farSide.txFrames[4], farSide.txFrames[3], farSide.txFrames[2],
            farSide.txFrames[1], farSide.txFrames[0]};
        `CHECK(word[47:0], 48'h4567_89ab_cdef)
        wb(`REG_INT_STATUS, 1'b0, 32'h0);
        `CHECK(rd[`INT_TX_DONE], 1'b1)
        // Second burst keeps the network period; restart while busy is ignored
        wb(`REG_NET_CTRL, 1'b1, 32'h0000_0001);
        wb(`REG_NET_CTRL, 1'b1, 32'h0000_0001);
        n = 0;
        while (statusBits[1] !== 1'b0 && n < 120) begin
            @(posedge ref_clk);
            n++;
        end
        `CHECK(n < 60, 1'b1)
        // Word returned clean, with one and with two flipped bits
        for (int j = 0; j < 3; j++) begin
            wb(`REG_INT_STATUS, 1'b1, 32'h0000_00ff);
            farSide.send_word(word ^ ((1 << j) - 1));
            if (j < 2) rd_chk(`REG_RX_LO, 32'h89ab_cdef);
            wb(`REG_INT_STATUS, 1'b0, 32'h0);
            `CHECK({rd[7], rd[3:2]}, (j == 0) ? 3'h4 : (j == 1) ? 3'h5 : 3'h6)
        end
        complete_run();
    end
endmodule
bind array_processor_node_interface node_properties chk (.ref_clk(ref_clk),
    .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .wiredNumber(wiredNumber), .spareCorrect(spareCorrect), .logicalNumber(logicalNumber),
    .statusBits(statusBits), .netTxData(netTxData), .netTxStrobe(netTxStrobe), .irq(irq));

// ---- testbench/node_far_side.sv ----
`timescale 1ns/100ps
// ****
// Coordinator and network model
// ****
module node_far_side (
    input wire logic ref_clk,
    output logic [3:0] cmdCode,
    output logic cmdStrobe,
    output logic goPulse,
    input wire logic [10:0] netTxData,
    input wire logic netTxStrobe,
    output logic [10:0] netRxData,
    output logic netRxStrobe,
    output logic netRxAck
);
    logic [10:0] txFrames [5]; // Last word seen from the node
    int txCount; // Cycles into current burst
    initial begin
        {cmdCode, cmdStrobe, goPulse, netRxData, netRxStrobe, netRxAck} = '0;
        txCount = 0;
    end
    // Capture each frame in its first cycle
    always @(posedge ref_clk) begin
        if (netTxStrobe) begin
            if (txCount % 4 == 0 && txCount < 20) begin
                txFrames[txCount / 4] <= netTxData;
            end
            txCount <= txCount + 1;
        end else begin
            txCount <= 0;
        end
    end
    // Strobe spans eight cycles so it covers one 40 ns tick
    task automatic issue(input logic [3:0] code, input logic go);
        @(posedge ref_clk);
        cmdCode <= code;
        cmdStrobe <= !go;
        goPulse <= go;
        repeat (8) @(posedge ref_clk);
        {cmdStrobe, goPulse} <= 2'h0;
        cmdCode <= ~code; // Released code does not keep its value
        repeat (16) @(posedge ref_clk);
    endtask
    // Five frames of four cycles under one strobe
    task automatic send_word(input logic [54:0] w);
        @(posedge ref_clk);
        netRxStrobe <= 1'b1;
        netRxAck <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            netRxData <= w[k*11 +: 11];
            repeat (4) @(posedge ref_clk);
        end
        {netRxStrobe, netRxAck} <= 2'h0;
        netRxData <= ~w[54:44];
    endtask
endmodule

// ---- testbench/node_properties.sv ----
`timescale 1ns/100ps
// ****
// Port checker
// ****
module node_properties (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [9:0] wiredNumber,
    input wire logic spareCorrect,
    input wire logic [9:0] logicalNumber,
    input wire logic [3:0] statusBits,
    input wire logic [10:0] netTxData,
    input wire logic netTxStrobe,
    input wire logic irq
);
    logic txPrev_q; // Strobe one cycle back
    logic seenRise_q; // A burst has started since reset
    logic [4:0] txRun_q; // High cycles of current burst
    logic [4:0] sinceRise_q; // Phase within the 24-cycle network period
    // Counters kept here so long spans need no repetition
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txPrev_q <= 1'b0;
            seenRise_q <= 1'b0;
            txRun_q <= 5'h00;
            sinceRise_q <= 5'h00;
        end else begin
            txPrev_q <= netTxStrobe;
            txRun_q <= netTxStrobe ? txRun_q + 5'h01 : 5'h00;
            // Restart phase on every burst start
            if (netTxStrobe && !txPrev_q) begin
                sinceRise_q <= 5'h01;
                seenRise_q <= 1'b1;
            end else begin
                sinceRise_q <= (sinceRise_q == 5'h17) ? 5'h00 : sinceRise_q + 5'h01;
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered next cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    number_map_a: assert property (
        logicalNumber == {wiredNumber[9:8], wiredNumber[7:0] - {7'h00, spareCorrect}})
        else $error("logical number wrong");
    frame_hold_a: assert property ($rose(netTxStrobe) |=> $stable(netTxData)[*3])
        else $error("tx frame not held four cycles");
    burst_length_a: assert property ($fell(netTxStrobe) |-> txRun_q == 5'h14)
        else $error("tx burst not twenty cycles");
    net_period_a: assert property (
        netTxStrobe && !txPrev_q && seenRise_q |-> sinceRise_q == 5'h00)
        else $error("tx burst off the network clock");
    tx_busy_a: assert property (netTxStrobe |-> statusBits[1])
        else $error("busy status low during send");
endmodule
